// >>> core/dsd_pkg.sv
// Constants shared by the data-space decoder and its leaf modules.
// Assumes an 8-bit data space and a 12-bit program memory address.
package dsd_pkg;

  localparam int ADDR_W = 8;
  localparam int DATA_W = 8;
  localparam int OFS_W = 6;
  localparam int BASE_W = 6;
  localparam int PROG_ADDR_W = 12;
  localparam int RAM_DEPTH = 60;
  localparam int PAGE_DEPTH = 64;

  localparam logic [7:0] ADDR_BANK_LO = 8'h00;
  localparam logic [7:0] ADDR_BANK_HI = 8'h3F;
  localparam logic [7:0] ADDR_WIN_LO = 8'h40;
  localparam logic [7:0] ADDR_WIN_HI = 8'h7F;
  localparam logic [7:0] ADDR_CORE_LO = 8'h80;
  localparam logic [7:0] ADDR_CORE_HI = 8'h83;
  localparam logic [7:0] ADDR_RAM_LO = 8'h84;
  localparam logic [7:0] ADDR_RAM_HI = 8'hBF;
  localparam logic [7:0] ADDR_ROM_WINDOW_BASE = 8'hC9;
  localparam logic [7:0] ADDR_BANK_SELECT = 8'hE8;
  localparam logic [7:0] ADDR_ACC = 8'hFF;

  localparam int BANK_RAM2_BIT = 4;
  localparam int BANK_EE0_BIT = 0;

  localparam logic [7:0] CORE_RESET = 8'h00;
  localparam logic [7:0] READ_NONE = 8'h00;

  typedef enum logic [1:0] {
    DSD_IDLE = 2'b00,
    DSD_PROG = 2'b01,
    DSD_EE = 2'b10,
    DSD_DONE = 2'b11
  } dsd_state_e;

endpackage : dsd_pkg

// >>> core/dsd_byte_ram.sv
// Byte-wide storage array with a clocked write and an immediate read.
// Assumes addresses stay below the depth; contents are undefined after power-up.
`timescale 1ns/1ns
module dsd_byte_ram #(
  parameter int DEPTH = 64,
  parameter int AW = 6
) (
  input wire logic clk_in,
  input wire logic ce_in,
  input wire logic we_in,
  input wire logic [AW-1:0] addr_in,
  input wire logic [7:0] wdata_in,
  output logic [7:0] rdata_out
);

  typedef struct packed {
    logic [DEPTH-1:0][7:0] mem;
  } dsd_ram_s;

  dsd_ram_s s_q;
  dsd_ram_s s_d;

  ////////////////////////////////////////////////////////////////////////////////
  // Write port and read port.
  always_comb begin
    s_d = s_q;
    if (we_in && (int'(addr_in) < DEPTH)) begin
      s_d.mem[addr_in] = wdata_in;
    end
  end

  always_ff @(posedge clk_in) begin
    if (ce_in) begin
      s_q <= s_d;
    end
  end

  assign rdata_out = (int'(addr_in) < DEPTH) ? s_q.mem[addr_in] : dsd_pkg::READ_NONE;

endmodule : dsd_byte_ram

// >>> core/dsd_rom_port.sv
// Program memory read port for the read-only data window.
// Assumes program memory holds its data valid in the cycle it raises its acknowledge.
`timescale 1ns/1ns
module dsd_rom_port (
  input wire logic clk_in,
  input wire logic rstn_in,
  input wire logic ce_in,
  input wire logic start_in,
  input wire logic [dsd_pkg::BASE_W-1:0] base_in,
  input wire logic [dsd_pkg::OFS_W-1:0] offset_in,
  output logic [dsd_pkg::PROG_ADDR_W-1:0] prog_addr_out,
  output logic prog_rd_out,
  input wire logic [7:0] prog_data_in,
  input wire logic prog_ack_in,
  output logic done_out,
  output logic [7:0] data_out
);

  typedef struct packed {
    logic [dsd_pkg::PROG_ADDR_W-1:0] addr;
    logic rd;
    logic done;
    logic [7:0] data;
  } dsd_rom_s;

  dsd_rom_s s_q;
  dsd_rom_s s_d;

  ////////////////////////////////////////////////////////////////////////////////
  // Address forming and read handshake.
  always_comb begin
    s_d = s_q;
    s_d.done = 1'b0;
    if (start_in && !s_q.rd) begin
      s_d.addr = {base_in, offset_in};
      s_d.rd = 1'b1;
    end else if (s_q.rd && prog_ack_in) begin
      s_d.rd = 1'b0;
      s_d.done = 1'b1;
      s_d.data = prog_data_in;
    end
  end

  always_ff @(posedge clk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      s_q <= '0;
    end else if (ce_in) begin
      s_q <= s_d;
    end
  end

  assign prog_addr_out = s_q.addr;
  assign prog_rd_out = s_q.rd;
  assign done_out = s_q.done;
  assign data_out = s_q.data;

endmodule : dsd_rom_port

// >>> core/dsd_decoder.sv
// Data-space address decoder with program memory window and banked page region.
// Assumes a classic Wishbone master with 8-bit data and an 8-bit data-space address.
`timescale 1ns/1ns
module dsd_decoder (
  input wire logic clk_in,
  input wire logic rstn_in,
  input wire logic ce_in,
  input wire logic wb_cyc_in,
  input wire logic wb_stb_in,
  input wire logic wb_we_in,
  input wire logic [dsd_pkg::ADDR_W-1:0] wb_adr_in,
  input wire logic [dsd_pkg::DATA_W-1:0] wb_dat_in,
  input wire logic [0:0] wb_sel_in,
  output logic [dsd_pkg::DATA_W-1:0] wb_dat_out,
  output logic wb_ack_out,
  output logic [dsd_pkg::PROG_ADDR_W-1:0] prog_addr_out,
  output logic prog_rd_out,
  input wire logic [7:0] prog_data_in,
  input wire logic prog_ack_in,
  output logic [dsd_pkg::OFS_W-1:0] ee_addr_out,
  output logic [7:0] ee_dat_out,
  output logic ee_we_out,
  output logic ee_stb_out,
  input wire logic [7:0] ee_dat_in,
  input wire logic ee_ack_in,
  output logic [7:0] acc_out
);

  typedef struct packed {
    dsd_pkg::dsd_state_e st;
    logic ack;
    logic [7:0] rdat;
    logic [dsd_pkg::BASE_W-1:0] win_base;
    logic [7:0] bank;
    logic [3:0][7:0] core;
    logic [7:0] acc;
    logic [dsd_pkg::OFS_W-1:0] ee_addr;
    logic [7:0] ee_dat;
    logic ee_we;
    logic ee_stb;
  } dsd_top_s;

  dsd_top_s s_q;
  dsd_top_s s_d;

  logic take;
  logic wr;
  logic hit_bank;
  logic hit_win;
  logic hit_core;
  logic hit_ram;
  logic hit_base;
  logic hit_bsel;
  logic hit_acc;
  logic pick_ram2;
  logic pick_ee0;
  logic [7:0] ram_diff;
  logic ram_we;
  logic page_we;
  logic rom_start;
  logic rom_done;
  logic [7:0] rom_data;
  logic [7:0] ram_rdata;
  logic [7:0] page_rdata;

  ////////////////////////////////////////////////////////////////////////////////
  // Address decode.
  always_comb begin
    take = wb_cyc_in && wb_stb_in && (s_q.st == dsd_pkg::DSD_IDLE);
    wr = wb_we_in && wb_sel_in[0];
    hit_bank = (wb_adr_in <= dsd_pkg::ADDR_BANK_HI);
    hit_win = (wb_adr_in >= dsd_pkg::ADDR_WIN_LO) && (wb_adr_in <= dsd_pkg::ADDR_WIN_HI);
    hit_core = (wb_adr_in >= dsd_pkg::ADDR_CORE_LO) && (wb_adr_in <= dsd_pkg::ADDR_CORE_HI);
    hit_ram = (wb_adr_in >= dsd_pkg::ADDR_RAM_LO) && (wb_adr_in <= dsd_pkg::ADDR_RAM_HI);
    hit_base = (wb_adr_in == dsd_pkg::ADDR_ROM_WINDOW_BASE);
    hit_bsel = (wb_adr_in == dsd_pkg::ADDR_BANK_SELECT);
    hit_acc = (wb_adr_in == dsd_pkg::ADDR_ACC);
    pick_ram2 = s_q.bank[dsd_pkg::BANK_RAM2_BIT];
    pick_ee0 = s_q.bank[dsd_pkg::BANK_EE0_BIT] && !pick_ram2;
    ram_diff = wb_adr_in - dsd_pkg::ADDR_RAM_LO;
    ram_we = take && wr && hit_ram;
    page_we = take && wr && hit_bank && pick_ram2;
    rom_start = take && hit_win && !wb_we_in;
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Storage blocks.
  dsd_byte_ram #(
    .DEPTH(dsd_pkg::RAM_DEPTH),
    .AW(dsd_pkg::OFS_W)
  ) u_ram (
    .clk_in(clk_in),
    .ce_in(ce_in),
    .we_in(ram_we),
    .addr_in(ram_diff[dsd_pkg::OFS_W-1:0]),
    .wdata_in(wb_dat_in),
    .rdata_out(ram_rdata)
  );

  dsd_byte_ram #(
    .DEPTH(dsd_pkg::PAGE_DEPTH),
    .AW(dsd_pkg::OFS_W)
  ) u_page2 (
    .clk_in(clk_in),
    .ce_in(ce_in),
    .we_in(page_we),
    .addr_in(wb_adr_in[dsd_pkg::OFS_W-1:0]),
    .wdata_in(wb_dat_in),
    .rdata_out(page_rdata)
  );

  dsd_rom_port u_rom (
    .clk_in(clk_in),
    .rstn_in(rstn_in),
    .ce_in(ce_in),
    .start_in(rom_start),
    .base_in(s_q.win_base),
    .offset_in(wb_adr_in[dsd_pkg::OFS_W-1:0]),
    .prog_addr_out(prog_addr_out),
    .prog_rd_out(prog_rd_out),
    .prog_data_in(prog_data_in),
    .prog_ack_in(prog_ack_in),
    .done_out(rom_done),
    .data_out(rom_data)
  );

  ////////////////////////////////////////////////////////////////////////////////
  // Bus slave sequencing and register updates.
  always_comb begin
    s_d = s_q;
    case (s_q.st)
      dsd_pkg::DSD_IDLE: begin
        s_d.ack = 1'b0;
        if (take) begin
          s_d.rdat = dsd_pkg::READ_NONE;
          s_d.ack = 1'b1;
          s_d.st = dsd_pkg::DSD_DONE;
          if (hit_bank) begin
            if (pick_ram2) begin
              s_d.rdat = page_rdata;
            end else if (pick_ee0) begin
              s_d.ack = 1'b0;
              s_d.st = dsd_pkg::DSD_EE;
              s_d.ee_addr = wb_adr_in[dsd_pkg::OFS_W-1:0];
              s_d.ee_dat = wb_dat_in;
              s_d.ee_we = wr;
              s_d.ee_stb = 1'b1;
            end
          end else if (hit_win) begin
            if (!wb_we_in) begin
              s_d.ack = 1'b0;
              s_d.st = dsd_pkg::DSD_PROG;
            end
            // Window writes are acknowledged and dropped.
          end else if (hit_core) begin
            s_d.rdat = s_q.core[wb_adr_in[1:0]];
            if (wr) begin
              s_d.core[wb_adr_in[1:0]] = wb_dat_in;
            end
          end else if (hit_ram) begin
            s_d.rdat = ram_rdata;
          end else if (hit_base) begin
            if (wr) begin
              s_d.win_base = wb_dat_in[dsd_pkg::BASE_W-1:0];
            end
          end else if (hit_bsel) begin
            if (wr) begin
              s_d.bank = wb_dat_in;
            end
          end else if (hit_acc) begin
            s_d.rdat = s_q.acc;
            if (wr) begin
              s_d.acc = wb_dat_in;
            end
          end
        end
      end
      dsd_pkg::DSD_PROG: begin
        if (rom_done) begin
          s_d.rdat = rom_data;
          s_d.ack = 1'b1;
          s_d.st = dsd_pkg::DSD_DONE;
        end
      end
      dsd_pkg::DSD_EE: begin
        if (ee_ack_in) begin
          s_d.rdat = s_q.ee_we ? dsd_pkg::READ_NONE : ee_dat_in;
          s_d.ee_stb = 1'b0;
          s_d.ee_we = 1'b0;
          s_d.ack = 1'b1;
          s_d.st = dsd_pkg::DSD_DONE;
        end
      end
      dsd_pkg::DSD_DONE: begin
        s_d.ack = 1'b0;
        s_d.st = dsd_pkg::DSD_IDLE;
      end
      default: begin
        s_d.ack = 1'b0;
        s_d.st = dsd_pkg::DSD_IDLE;
      end
    endcase
  end

  always_ff @(posedge clk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      s_q.st <= dsd_pkg::DSD_IDLE;
      s_q.ack <= 1'b0;
      s_q.rdat <= dsd_pkg::READ_NONE;
      s_q.core <= {4{dsd_pkg::CORE_RESET}};
      s_q.acc <= dsd_pkg::CORE_RESET;
      s_q.ee_addr <= '0;
      s_q.ee_dat <= dsd_pkg::CORE_RESET;
      s_q.ee_we <= 1'b0;
      s_q.ee_stb <= 1'b0;
      // Window base and bank select keep their contents through reset.
    end else if (ce_in) begin
      s_q <= s_d;
    end
  end

  assign wb_dat_out = s_q.rdat;
  assign wb_ack_out = s_q.ack;
  assign ee_addr_out = s_q.ee_addr;
  assign ee_dat_out = s_q.ee_dat;
  assign ee_we_out = s_q.ee_we;
  assign ee_stb_out = s_q.ee_stb;
  assign acc_out = s_q.acc;

endmodule : dsd_decoder

// >>> tb/dsd_far_model.sv
// Program memory and EEPROM page model facing the decoder.
// Assumes each request is held until the answer edge.
`timescale 1ns/1ns
module dsd_far_model (
  input wire logic clk_in,
  input wire logic slow_in,
  input wire logic [11:0] prog_addr_in,
  input wire logic prog_rd_in,
  output logic [7:0] prog_data_out,
  output logic prog_ack_out,
  input wire logic [5:0] ee_addr_in,
  input wire logic [7:0] ee_dat_in,
  input wire logic ee_we_in,
  input wire logic ee_stb_in,
  output logic [7:0] ee_dat_out,
  output logic ee_ack_out
);
  logic [7:0] mem [64];
  logic [7:0] pv;
  logic [1:0] pc;
  logic [1:0] ec;
  assign pv = prog_addr_in[7:0] ^ {2'h0, prog_addr_in[11:6]};
  // Data outside the answer cycle is the inverse.
  assign prog_data_out = prog_ack_out ? pv : ~pv;
  assign ee_dat_out = ee_ack_out ? mem[ee_addr_in] : ~mem[ee_addr_in];
  initial begin
    prog_ack_out = 1'b0;
    ee_ack_out = 1'b0;
    pc = 2'h0;
    ec = 2'h0;
  end
  always @(posedge clk_in) begin
    prog_ack_out <= 1'b0;
    ee_ack_out <= 1'b0;
    if (prog_rd_in && !prog_ack_out) begin
      pc <= (pc == {slow_in, slow_in}) ? 2'h0 : pc + 2'h1;
      prog_ack_out <= (pc == {slow_in, slow_in});
    end
    if (ee_stb_in && !ee_ack_out) begin
      ec <= (ec == {slow_in, 1'b0}) ? 2'h0 : ec + 2'h1;
      ee_ack_out <= (ec == {slow_in, 1'b0});
      if (ec == {slow_in, 1'b0} && ee_we_in) begin
        mem[ee_addr_in] <= ee_dat_in;
      end
    end
  end
endmodule : dsd_far_model

// >>> tb/dsd_decoder_asserts.sv
// Checker on the decoder's ports.
// Assumes one clock domain and the Wishbone master of the bench.
`timescale 1ns/1ns
module dsd_decoder_asserts (
  input wire logic clk_in,
  input wire logic rstn_in,
  input wire logic ce_in,
  input wire logic wb_cyc_in,
  input wire logic wb_stb_in,
  input wire logic wb_we_in,
  input wire logic [7:0] wb_adr_in,
  input wire logic wb_ack_out,
  input wire logic [11:0] prog_addr_out,
  input wire logic prog_rd_out,
  input wire logic prog_ack_in,
  input wire logic [5:0] ee_addr_out,
  input wire logic ee_we_out,
  input wire logic ee_stb_out,
  input wire logic ee_ack_in
);
  default clocking cb @(posedge clk_in); endclocking
  default disable iff (!rstn_in);
  property p_ack_pulse; wb_ack_out |=> !wb_ack_out; endproperty
  a_ack_pulse: assert property (p_ack_pulse) else $error("ack too long");
  property p_win_adr; $rose(prog_rd_out) |-> prog_addr_out[5:0] == $past(wb_adr_in[5:0]); endproperty
  a_win_adr: assert property (p_win_adr) else $error("window offset");
  property p_win_rd; $rose(prog_rd_out) |-> $past(wb_adr_in[7:6]) == 2'b01 && !$past(wb_we_in); endproperty
  a_win_rd: assert property (p_win_rd) else $error("stray fetch");
  property p_win_ack; prog_rd_out && prog_ack_in |=> !prog_rd_out ##1 wb_ack_out; endproperty
  a_win_ack: assert property (p_win_ack) else $error("window answer");
  property p_rd_hold; prog_rd_out && !prog_ack_in |=> prog_rd_out && $stable(prog_addr_out); endproperty
  a_rd_hold: assert property (p_rd_hold) else $error("fetch dropped");
  property p_ee_ack; ee_stb_out && ee_ack_in |=> wb_ack_out && !ee_stb_out; endproperty
  a_ee_ack: assert property (p_ee_ack) else $error("page answer");
  property p_ee_go; $rose(ee_stb_out) |-> $past(wb_adr_in[7:6]) == 2'b00 && ee_addr_out == $past(wb_adr_in[5:0])
    && ee_we_out == $past(wb_we_in); endproperty
  a_ee_go: assert property (p_ee_go) else $error("page request");
  property p_int_ack; ce_in && wb_cyc_in && wb_stb_in && !wb_ack_out && !prog_rd_out && !ee_stb_out
    && (wb_adr_in[7] || (wb_adr_in[7:6] == 2'b01 && wb_we_in)) |=> wb_ack_out && !prog_rd_out; endproperty
  a_int_ack: assert property (p_int_ack) else $error("internal answer");
endmodule : dsd_decoder_asserts
bind dsd_decoder dsd_decoder_asserts dsd_decoder_asserts_inst (
  .clk_in(clk_in),
  .rstn_in(rstn_in),
  .ce_in(ce_in),
  .wb_cyc_in(wb_cyc_in),
  .wb_stb_in(wb_stb_in),
  .wb_we_in(wb_we_in),
  .wb_adr_in(wb_adr_in),
  .wb_ack_out(wb_ack_out),
  .prog_addr_out(prog_addr_out),
  .prog_rd_out(prog_rd_out),
  .prog_ack_in(prog_ack_in),
  .ee_addr_out(ee_addr_out),
  .ee_we_out(ee_we_out),
  .ee_stb_out(ee_stb_out),
  .ee_ack_in(ee_ack_in)
);

// >>> tb/testbench.sv
// Wishbone bench for the data-space decoder.
// Assumes the far side model answers program and page requests.
`timescale 1ns/1ns
module testbench;
  logic clk_in, rstn_in, cyc, stb, we, slow, ack, prd, pak, ewe, estb, eak, ce, sel;
  logic [7:0] adr, dat, wdo, acc, pdi, edi, edo, q;
  logic [11:0] pad;
  logic [5:0] ead;
  logic [7:0] ta [7] = '{8'h80, 8'h81, 8'h82, 8'h83, 8'h84, 8'hBF, 8'hFF};
  logic [7:0] td [7] = '{8'h11, 8'h22, 8'h33, 8'h44, 8'hA5, 8'h5A, 8'hC3};
  logic [7:0] bs [3] = '{8'h00, 8'h3F, 8'hEA};
  int err_total, checked;
  dsd_decoder dsd_decoder_inst (.clk_in(clk_in), .rstn_in(rstn_in), .ce_in(ce), .wb_cyc_in(cyc),
    .wb_stb_in(stb), .wb_we_in(we), .wb_adr_in(adr), .wb_dat_in(dat), .wb_sel_in(sel), .wb_dat_out(wdo),
    .wb_ack_out(ack), .prog_addr_out(pad), .prog_rd_out(prd), .prog_data_in(pdi), .prog_ack_in(pak),
    .ee_addr_out(ead), .ee_dat_out(edo), .ee_we_out(ewe), .ee_stb_out(estb), .ee_dat_in(edi),
    .ee_ack_in(eak), .acc_out(acc));
  dsd_far_model dsd_far_model_inst (.clk_in(clk_in), .slow_in(slow), .prog_addr_in(pad), .prog_rd_in(prd),
    .prog_data_out(pdi), .prog_ack_out(pak), .ee_addr_in(ead), .ee_dat_in(edo), .ee_we_in(ewe),
    .ee_stb_in(estb), .ee_dat_out(edi), .ee_ack_out(eak));
  ////////////////////////////////////////////////////////////////
  function automatic logic [7:0] pb(input logic [11:0] a);
    return a[7:0] ^ {2'h0, a[11:6]};
  endfunction : pb
  task automatic results();
    $display("checked %0d err_total %0d", checked, err_total);
    if (err_total == 0 && checked > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask : results
  task automatic check(input logic [11:0] s, input logic [11:0] e);
    checked++;
    if (s !== e) begin
      err_total++;
      $display("[ERR] %0t got %h want %h", $time, s, e);
    end
  endtask : check
  task automatic xfer(input logic w, input logic [7:0] a, input logic [7:0] d);
    int n;
    n = 0;
    cyc <= 1'b1;
    stb <= 1'b1;
    we <= w;
    adr <= a;
    dat <= d;
    @(posedge clk_in);
    while (ack !== 1'b1) begin
      if (n == 40) begin
        err_total++;
        results();
      end
      n++;
      @(posedge clk_in);
    end
    q = wdo;
    cyc <= 1'b0;
    stb <= 1'b0;
    @(posedge clk_in);
  endtask : xfer
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    xfer(1'b1, a, d);
  endtask : wr
  task automatic rd(input logic [7:0] a, input logic [7:0] e);
    xfer(1'b0, a, 8'h00);
    check({4'h0, q}, {4'h0, e});
  endtask : rd
  ////////////////////////////////////////////////////////////////
  initial begin
    clk_in = 1'b0;
    forever #20 clk_in = ~clk_in;
  end
  initial begin
    {rstn_in, cyc, stb, we, slow, adr, dat, err_total, checked} = '0;
    {ce, sel} = 2'b11;
    repeat (2) @(posedge clk_in);
    rstn_in <= 1'b1;
    foreach (ta[i]) wr(ta[i], td[i]);
    foreach (ta[i]) rd(ta[i], td[i]);
    check({4'h0, acc}, 12'h0C3);
    sel <= 1'b0;
    wr(8'h81, 8'hEE);
    sel <= 1'b1;
    rd(8'h81, 8'h22);
    ce <= 1'b0;
    cyc <= 1'b1;
    stb <= 1'b1;
    we <= 1'b1;
    adr <= 8'h80;
    dat <= 8'h66;
    repeat (2) @(posedge clk_in);
    check({11'h000, ack}, 12'h000);
    ce <= 1'b1;
    wr(8'h80, 8'h66);
    rd(8'h80, 8'h66);
    $display("test core done");
    wr(8'hC9, 8'hC1);
    slow <= 1'b1;
    rd(8'h45, pb(12'h045));
    check(pad, 12'h045);
    slow <= 1'b0;
    wr(8'h45, 8'h99);
    rd(8'h45, pb(12'h045));
    foreach (bs[i]) begin
      wr(8'hC9, bs[i]);
      rd(8'h40, pb({bs[i][5:0], 6'h00}));
      rd(8'h7F, pb({bs[i][5:0], 6'h3F}));
      check(pad, {bs[i][5:0], 6'h3F});
    end
    rd(8'hC9, 8'h00);
    rd(8'hE8, 8'h00);
    rd(8'hC3, 8'h00);
    $display("test window done");
    wr(8'hE8, 8'h10);
    wr(8'h00, 8'hA5);
    wr(8'h3F, 8'h5A);
    wr(8'hE8, 8'h01);
    slow <= 1'b1;
    wr(8'h3F, 8'h3C);
    check({4'h0, edo}, 12'h03C);
    rd(8'h3F, 8'h3C);
    check({6'h00, ead}, 12'h03F);
    slow <= 1'b0;
    wr(8'hE8, 8'h11);
    rd(8'h00, 8'hA5);
    rd(8'h3F, 8'h5A);
    wr(8'hE8, 8'h00);
    wr(8'h00, 8'h77);
    rd(8'h00, 8'h00);
    wr(8'hE8, 8'h10);
    $display("test bank done");
    rstn_in <= 1'b0;
    repeat (2) @(posedge clk_in);
    rstn_in <= 1'b1;
    rd(8'h80, 8'h00);
    check({4'h0, acc}, 12'h000);
    rd(8'h45, pb(12'hA85));
    rd(8'h00, 8'hA5);
    $display("test reset done");
    results();
  end
endmodule : testbench
